// File: include/ssm_pkg.sv
// Package of constants for the SRAM sleep mode controller
package ssm_pkg;
  // Clock period in picoseconds (50 MHz)
  localparam int CLK_PERIOD_PS = 20000;
  // Cycles from stable request to sleep entry
  localparam int ENTRY_CYCLES = 2;
  // Cycles from stable release to normal operation
  localparam int WAKE_CYCLES = 2;
  // Least recovery time after the request falls, in ns
  localparam int RECOVERY_NS = 20;
  // Recovery time as whole cycles, rounded up, at least one
  localparam int RECOVERY_CYCLES_RAW =
    (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVERY_CYCLES =
    (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;
  // Width of the delay counter
  localparam int CNT_W = 3;
  // Reset value of the delay counter
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
  // Power states
  typedef enum logic [1:0] {
    AWAKE, ENTERING, ASLEEP, WAKING
  } ssm_state_t;
endpackage

// File: rtl/ssm_sleep_ctrl.sv
// Sleep entry and exit controller of the synchronous SRAM
`timescale 1ns/100ps
module ssm_sleep_ctrl #(
  parameter int ENTRY = ssm_pkg::ENTRY_CYCLES,
  parameter int WAKE = ssm_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Asynchronous sleep request from the controller
  input wire logic sleepRequest,
  // Controls toward the SRAM core
  output logic sleepActive,
  output logic inputsEnabled,
  output logic dataOutEnable,
  output logic deselectForce,
  output logic recovering
);

  // All state of the module
  typedef struct packed {
    logic s1;                        // Synchroniser stage one
    logic s2;                        // Synchroniser stage two
    logic s3;                        // Synchroniser stage three
    logic req;                       // Accepted request level
    ssm_pkg::ssm_state_t st;         // Power state
    logic [ssm_pkg::CNT_W-1:0] cnt;  // Delay counter
    logic asleep;                    // Output register
    logic inEn;                      // Output register
    logic oeEn;                      // Output register
    logic desel;                     // Output register
    logic recov;                     // Output register
  } ssm_reg_t;

  ssm_reg_t state_r;
  ssm_reg_t state_nxt;

  // Next counter value, saturating
  function automatic logic [ssm_pkg::CNT_W-1:0] cntInc(
    input logic [ssm_pkg::CNT_W-1:0] c
  );
    cntInc = (c == '1) ? c : c + 3'h1;
  endfunction

  // Next state logic
  always_comb begin
    state_nxt = state_r;
    // Three stage synchroniser, s1 read only by s2
    state_nxt.s1 = sleepRequest;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    // Level accepted once stages two and three agree
    if (state_r.s2 == state_r.s3) begin
      state_nxt.req = state_r.s2;
    end
    case (state_r.st)
      ssm_pkg::AWAKE: begin
        state_nxt.cnt = ssm_pkg::CNT_RST;
        if (state_r.req) begin
          state_nxt.st = ssm_pkg::ENTERING;
          state_nxt.cnt = 3'h1;
        end
      end
      ssm_pkg::ENTERING: begin
        // Request dropped early: abandon entry
        if (!state_r.req) begin
          state_nxt.st = ssm_pkg::AWAKE;
        end else if (state_r.cnt >= 3'(ENTRY)) begin
          state_nxt.st = ssm_pkg::ASLEEP;
        end else begin
          state_nxt.cnt = cntInc(state_r.cnt);
        end
      end
      ssm_pkg::ASLEEP: begin
        // Stays as long as the request stays high
        if (!state_r.req) begin
          state_nxt.st = ssm_pkg::WAKING;
          state_nxt.cnt = 3'h1;
        end
      end
      ssm_pkg::WAKING: begin
        // Request back high: return straight to sleep
        if (state_r.req) begin
          state_nxt.st = ssm_pkg::ASLEEP;
        end else if (state_r.cnt >= 3'(WAKE)) begin
          state_nxt.st = ssm_pkg::AWAKE;
        end else begin
          state_nxt.cnt = cntInc(state_r.cnt);
        end
      end
      default: begin
        state_nxt.st = ssm_pkg::AWAKE;
      end
    endcase
    // Outputs registered from the next state
    state_nxt.asleep = (state_nxt.st == ssm_pkg::ASLEEP);
    state_nxt.inEn = !state_nxt.asleep;
    state_nxt.oeEn = !state_nxt.asleep;
    state_nxt.desel = state_nxt.asleep;
    // Recovery: only deselect or read expected from the controller
    state_nxt.recov = (state_nxt.st == ssm_pkg::WAKING);
  end

  // State register; core contents are untouched by sleep, no clear here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, req: 1'b0,
                   st: ssm_pkg::AWAKE, cnt: ssm_pkg::CNT_RST,
                   asleep: 1'b0, inEn: 1'b1, oeEn: 1'b1,
                   desel: 1'b0, recov: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign sleepActive = state_r.asleep;
  assign inputsEnabled = state_r.inEn;
  assign dataOutEnable = state_r.oeEn;
  assign deselectForce = state_r.desel;
  assign recovering = state_r.recov;

  // Entry: accepted request held causes sleep
  sequence reqHeld;
    state_r.req [*3];
  endsequence
  property entryProp;
    @(posedge sys_clk) disable iff (!nrst)
      ($rose(state_r.req) ##0 reqHeld) |=> sleepActive;
  endproperty
  AST_ENTRY: assert property (entryProp)
    else $error("sleep not entered after held request");

  // Only a fresh request from the awake state; a rise during wake-up
  // returns to sleep at once by design
  AST_NO_EARLY: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($rose(state_r.req) && state_r.st == ssm_pkg::AWAKE)
      |=> !sleepActive [*2])
    else $error("sleep entered too early");

  AST_WAKE: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($fell(state_r.req) ##0 !state_r.req [*3]) |=> !sleepActive)
    else $error("device did not wake");

  AST_STAY: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleepActive && state_r.req) |=> sleepActive)
    else $error("left sleep while request high");

  AST_DESEL: assert property (@(posedge sys_clk) disable iff (!nrst)
    sleepActive |-> deselectForce && !recovering)
    else $error("not deselected while asleep");

  AST_FLOAT: assert property (@(posedge sys_clk) disable iff (!nrst)
    sleepActive |-> !dataOutEnable && !inputsEnabled)
    else $error("outputs driven while asleep");

  AST_RECOV: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(sleepActive) && !state_r.req |-> recovering)
    else $error("recovery not flagged on wake");

  AST_SYNC: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r.s2 == state_r.s3)
      |=> state_r.req == $past(state_r.s2))
    else $error("request level not accepted");

  // Held state while the request stays high; the wake edge reloads cnt
  AST_RETAIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleepActive && state_r.req) |=> $stable(state_r.cnt))
    else $error("state changed while asleep");

  // Entry cut short by a dropped request never reaches sleep
  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r.st == ssm_pkg::ENTERING && !state_r.req)
      |=> !sleepActive)
    else $error("sleep entered after dropped request");

  // Request back high during wake-up: straight back to sleep
  AST_RESLEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_r.st == ssm_pkg::WAKING && state_r.req)
      |=> sleepActive)
    else $error("no return to sleep during wake-up");

  // Wake-up window opens with the request low for its whole length
  sequence wakeStart;
    $rose(recovering) ##0 !state_r.req [*2];
  endsequence
  // Window checked open two cycles, then closed; the design holds it the two wake cycles, 40 ns, which covers recovery
  AST_WIN_LEN: assert property (@(posedge sys_clk) disable iff (!nrst)
    wakeStart |-> recovering ##1 !recovering)
    else $error("wake-up window length wrong");

endmodule

// File: tb/ssm_ctrl_model.sv
// Memory controller model driving the sleep request
`timescale 1ns/100ps
module ssm_ctrl_model (
  // Bench command
  input wire logic sleepCmd,
  // Wake-up window flag from the block
  input wire logic recovering,
  // Toward the block
  output logic sleepRequest,
  output logic writeAllowed
);
  // No queued operations here, so a raise never cuts one short
  assign sleepRequest = sleepCmd;
  // Writes held off in the wake-up window
  assign writeAllowed = !recovering && !sleepRequest;
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the sleep controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  // Clock, reset, command
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic sleepCmd = 1'h0;
  // Model and block outputs
  logic sleepRequest, writeAllowed;
  logic sleepActive, inputsEnabled, dataOutEnable, deselectForce, recovering;
  int err_count = 0;
  int checks_done = 0;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  ssm_sleep_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst),
    .sleepRequest(sleepRequest), .sleepActive(sleepActive),
    .inputsEnabled(inputsEnabled), .dataOutEnable(dataOutEnable),
    .deselectForce(deselectForce), .recovering(recovering));
  ssm_ctrl_model ctl_u (.sleepCmd(sleepCmd), .recovering(recovering),
    .sleepRequest(sleepRequest), .writeAllowed(writeAllowed));
  // Wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // All five outputs against one pattern
  task automatic look(input string n, input logic [4:0] e);
    `CHK(n, e, {sleepActive, inputsEnabled, dataOutEnable,
      deselectForce, recovering})
  endtask
  // Awake values during and after reset
  task automatic t_reset();
    look("reset", 5'h0c);
    nrst = 1'h1;
    tick(1);
    look("awake", 5'h0c);
  endtask
  // Entry lands on the documented edge, not one before
  task automatic t_entry();
    sleepCmd = 1'h1;
    tick(6);
    look("entering", 5'h0c);
    tick(1);
    look("asleep", 5'h12);
  endtask
  // Long stay asleep
  task automatic t_hold();
    tick(40);
    look("held", 5'h12);
  endtask
  // Wake-up window then normal
  task automatic t_exit();
    sleepCmd = 1'h0;
    tick(5);
    look("waking", 5'h0d);
    `CHK("writeAllowed", 1'h0, writeAllowed)
    tick(2);
    look("woken", 5'h0c);
    `CHK("writeAllowed", 1'h1, writeAllowed)
  endtask
  // Two-cycle pulse: entry starts, then is abandoned
  task automatic t_abort();
    sleepCmd = 1'h1;
    tick(2);
    sleepCmd = 1'h0;
    tick(8);
    look("aborted", 5'h0c);
  endtask
  // Short release: wake-up begins, request returns, sleep again
  task automatic t_resleep();
    t_entry();
    sleepCmd = 1'h0;
    tick(2);
    sleepCmd = 1'h1;
    tick(3);
    look("rewaking", 5'h0d);
    tick(2);
    look("asleep again", 5'h12);
    sleepCmd = 1'h0;
    tick(8);
    look("awake again", 5'h0c);
  endtask
  // Reset in mid-sleep returns awake values
  task automatic t_rst_sleep();
    t_entry();
    nrst = 1'h0;
    sleepCmd = 1'h0;
    tick(1);
    look("reset asleep", 5'h0c);
    nrst = 1'h1;
    tick(10);
    look("after reset", 5'h0c);
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence; reset held five cycles
  initial begin
    tick(5);
    t_reset();
    t_abort();
    t_entry();
    t_hold();
    t_exit();
    t_resleep();
    t_rst_sleep();
    stop_test();
  end
  // Watchdog, well beyond the hundred-odd cycles needed
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
